/* verilog/ils_pkg.sv */
// shared constants, register map and state types of the priority-level block
package ils_pkg;

	// AXI4-Lite geometry
	localparam int unsigned AXI_AW   = 8;
	localparam int unsigned AXI_DW   = 32;
	localparam int unsigned REG_W    = 16;
	localparam int unsigned FIELD_W  = 2;
	localparam int unsigned NUM_SRC  = 22;

	// register indices as printed; byte address is four times the index
	localparam logic [AXI_AW-1:0] IDX_LEVEL_SEL_FIVE  = 8'h05;
	localparam logic [AXI_AW-1:0] IDX_LEVEL_SEL_SIX   = 8'h06;
	localparam logic [AXI_AW-1:0] IDX_LEVEL_SEL_SEVEN = 8'h07;
	localparam int unsigned       BYTE_ADDR_LSB       = 2;

	// reset values
	localparam logic [REG_W-1:0] RST_LEVEL_SEL = 16'h0000;

	// writable bits: reserved pairs are masked out
	localparam logic [REG_W-1:0] WMASK_FIVE  = 16'hFF3F;
	localparam logic [REG_W-1:0] WMASK_SIX   = 16'hFFCF;
	localparam logic [REG_W-1:0] WMASK_SEVEN = 16'hFFFF;

	// priority_level_field encodings
	localparam logic [FIELD_W-1:0] CODE_DISABLED = 2'h0;
	localparam logic [FIELD_W-1:0] CODE_LEVEL0   = 2'h1;
	localparam logic [FIELD_W-1:0] CODE_LEVEL1   = 2'h2;
	localparam logic [FIELD_W-1:0] CODE_LEVEL2   = 2'h3;
	localparam logic [FIELD_W-1:0] LEVEL_0       = 2'h0;
	localparam logic [FIELD_W-1:0] LEVEL_1       = 2'h1;
	localparam logic [FIELD_W-1:0] LEVEL_2       = 2'h2;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// bit offset of each register in the {seven, six, five} concatenation
	localparam int unsigned BASE_FIVE  = 0;
	localparam int unsigned BASE_SIX   = 16;
	localparam int unsigned BASE_SEVEN = 32;

	// source order and field lsb in the concatenation
	localparam int unsigned SRC_POS [NUM_SRC] = '{
		// RULE6 decoder1 index, home/watchdog
		BASE_FIVE + 14, BASE_FIVE + 12,
		// RULE7 serial1 rx full, rx error
		BASE_FIVE + 10, BASE_FIVE + 8,
		// RULE8 serial1 tx idle, tx empty
		BASE_FIVE + 4, BASE_FIVE + 2,
		// RULE9 spi port0 tx empty
		BASE_FIVE + 0,
		// RULE10 timer c ch0
		BASE_SIX + 14,
		// RULE11 timer d ch3..ch0
		BASE_SIX + 12, BASE_SIX + 10, BASE_SIX + 8, BASE_SIX + 6,
		// RULE12 decoder0 index, home/watchdog
		BASE_SIX + 2, BASE_SIX + 0,
		// RULE13 timer a ch0, timer b ch3..ch0
		BASE_SEVEN + 14, BASE_SEVEN + 12, BASE_SEVEN + 10,
		BASE_SEVEN + 8, BASE_SEVEN + 6,
		// RULE14 timer c ch3..ch1
		BASE_SEVEN + 4, BASE_SEVEN + 2, BASE_SEVEN + 0
	};

	// register-side state
	typedef struct packed
	{
		logic [REG_W-1:0]  level_sel_five;
		logic [REG_W-1:0]  level_sel_six;
		logic [REG_W-1:0]  level_sel_seven;
		logic              aw_got;
		logic              w_got;
		logic [AXI_AW-1:0] awaddr;
		logic [REG_W-1:0]  wdata;
		logic [1:0]        wstrb;
		logic              bvalid;
		logic [1:0]        bresp;
		logic              rvalid;
		logic [1:0]        rresp;
		logic [AXI_DW-1:0] rdata;
	} ils_regs_s;

	// decoder-side state
	typedef struct packed
	{
		logic [NUM_SRC-1:0]              enable;
		logic [NUM_SRC-1:0][FIELD_W-1:0] level;
		logic [NUM_SRC-1:0]              req;
	} ils_dec_s;

endpackage

/* verilog/ils_prio_if.sv */
// carrier between the register file and the per-source level decoder
interface ils_prio_if;
	import ils_pkg::*;

	logic [NUM_SRC-1:0][FIELD_W-1:0] field;
	logic [NUM_SRC-1:0]              raw_irq;
	logic [NUM_SRC-1:0]              enable;
	logic [NUM_SRC-1:0][FIELD_W-1:0] level;
	logic [NUM_SRC-1:0]              req;

	modport regs (output field, output raw_irq,
		input enable, input level, input req);
	modport dec (input field, input raw_irq,
		output enable, output level, output req);
endinterface

/* verilog/ils_level_dec.sv */
// per-source decode of priority codes into enable, level and gated request
module ils_level_dec
	import ils_pkg::*;
(
	// clock and reset
	input  wire logic  mclk,
	input  wire logic  srst,
	// fields in, decoded view out
	ils_prio_if.dec    pif
);
	import ils_pkg::*;

	ils_dec_s r_reg;
	ils_dec_s r_next;

	////////////////////////////////////////////////////////////////////
	always_comb
	begin
		r_next = r_reg;
		for (int i = 0; i < NUM_SRC; i++)
		begin
			unique case (pif.field[i])
				// RULE1 code zero disables
				CODE_DISABLED:
				begin
					r_next.enable[i] = 1'b0;
					r_next.level[i]  = LEVEL_0;
				end
				// RULE2 code to level
				CODE_LEVEL0:
				begin
					r_next.enable[i] = 1'b1;
					r_next.level[i]  = LEVEL_0;
				end
				CODE_LEVEL1:
				begin
					r_next.enable[i] = 1'b1;
					r_next.level[i]  = LEVEL_1;
				end
				// RULE3 top code stops at level 2
				CODE_LEVEL2:
				begin
					r_next.enable[i] = 1'b1;
					r_next.level[i]  = LEVEL_2;
				end
			endcase
			// RULE15 disabled source never requests
			r_next.req[i] = pif.raw_irq[i] && (pif.field[i] != CODE_DISABLED);
		end
	end

	always_ff @(posedge mclk)
	begin
		if (srst)
			r_reg <= '0;
		else
			r_reg <= r_next;
	end

	////////////////////////////////////////////////////////////////////
	assign pif.enable = r_reg.enable;
	assign pif.level  = r_reg.level;
	assign pif.req    = r_reg.req;
endmodule

/* verilog/ils_top.sv */
// priority-level registers five to seven behind an AXI4-Lite slave
//
// Behaviour
// RULE1: code 00 disables source, reset default
// RULE2: codes 01,10,11 give levels 0,1,2
// RULE3: no encoding selects level above two
// RULE4: reserved pairs read zero, ignore writes
// RULE5: all three registers reset to zero
// RULE6: register five: decoder1 index, home fields
// RULE7: register five: serial1 rx full, rx error
// RULE8: register five: serial1 tx idle, tx empty
// RULE9: register five bits 1-0: spi0 tx empty
// RULE10: register six bits 15-14: timer c0
// RULE11: register six: timer d3..d0 fields
// RULE12: register six: decoder0 index, home fields
// RULE13: register seven: timer a0, timer b3..b0
// RULE14: register seven: timer c3..c1 low fields
// RULE15: forward enable and level; gate requests
//
// Chosen here: register access over AXI4-Lite.
module ils_top
	import ils_pkg::*;
(
	// clock and reset
	input  wire logic                            mclk,
	input  wire logic                            srst,
	// AXI4-Lite write address
	input  wire logic                            s_axi_awvalid,
	output logic                                 s_axi_awready,
	input  wire logic [ils_pkg::AXI_AW-1:0]      s_axi_awaddr,
	// AXI4-Lite write data
	input  wire logic                            s_axi_wvalid,
	output logic                                 s_axi_wready,
	input  wire logic [ils_pkg::AXI_DW-1:0]      s_axi_wdata,
	input  wire logic [3:0]                      s_axi_wstrb,
	// AXI4-Lite write response
	output logic                                 s_axi_bvalid,
	input  wire logic                            s_axi_bready,
	output logic [1:0]                           s_axi_bresp,
	// AXI4-Lite read address
	input  wire logic                            s_axi_arvalid,
	output logic                                 s_axi_arready,
	input  wire logic [ils_pkg::AXI_AW-1:0]      s_axi_araddr,
	// AXI4-Lite read data
	output logic                                 s_axi_rvalid,
	input  wire logic                            s_axi_rready,
	output logic [ils_pkg::AXI_DW-1:0]           s_axi_rdata,
	output logic [1:0]                           s_axi_rresp,
	// peripheral sources and arbitration side
	input  wire logic [ils_pkg::NUM_SRC-1:0]     src_irq_in,
	output logic [ils_pkg::NUM_SRC-1:0]          src_enable,
	output logic [ils_pkg::NUM_SRC-1:0][1:0]     src_level,
	output logic [ils_pkg::NUM_SRC-1:0]          src_req
);
	import ils_pkg::*;

	localparam logic [AXI_AW-1:0] ADDR_FIVE  =
		AXI_AW'(IDX_LEVEL_SEL_FIVE << BYTE_ADDR_LSB);
	localparam logic [AXI_AW-1:0] ADDR_SIX   =
		AXI_AW'(IDX_LEVEL_SEL_SIX << BYTE_ADDR_LSB);
	localparam logic [AXI_AW-1:0] ADDR_SEVEN =
		AXI_AW'(IDX_LEVEL_SEL_SEVEN << BYTE_ADDR_LSB);

	ils_regs_s r_reg;
	ils_regs_s r_next;
	logic      write_go;
	logic      write_hit;

	ils_prio_if pif ();

	////////////////////////////////////////////////////////////////////
	// byte-lane merge; only lanes 0 and 1 hold register bits
	function automatic logic [REG_W-1:0] merge
	(
		input logic [REG_W-1:0] old_v,
		input logic [REG_W-1:0] new_v,
		input logic [1:0]       strb,
		input logic [REG_W-1:0] wmask
	);
		logic [REG_W-1:0] m;
		m = old_v;
		if (strb[0])
			m[7:0] = new_v[7:0];
		if (strb[1])
			m[15:8] = new_v[15:8];
		return m & wmask;
	endfunction

	// sub-word address bits are ignored, as AXI4-Lite allows
	function automatic logic [AXI_AW-1:0] word_addr
	(
		input logic [AXI_AW-1:0] a
	);
		return {a[AXI_AW-1:BYTE_ADDR_LSB], {BYTE_ADDR_LSB{1'b0}}};
	endfunction

	////////////////////////////////////////////////////////////////////
	// address and data channels accept independently; the write lands
	// once both are held, so either order works
	assign s_axi_awready = !r_reg.aw_got && !r_reg.bvalid;
	assign s_axi_wready  = !r_reg.w_got && !r_reg.bvalid;
	assign s_axi_arready = !r_reg.rvalid;
	assign write_go      = r_reg.aw_got && r_reg.w_got;
	assign write_hit     = (word_addr(r_reg.awaddr) == ADDR_FIVE)
		|| (word_addr(r_reg.awaddr) == ADDR_SIX)
		|| (word_addr(r_reg.awaddr) == ADDR_SEVEN);

	always_comb
	begin
		r_next = r_reg;

		if (s_axi_awvalid && s_axi_awready)
		begin
			r_next.aw_got = 1'b1;
			r_next.awaddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready)
		begin
			r_next.w_got = 1'b1;
			r_next.wdata = s_axi_wdata[REG_W-1:0];
			r_next.wstrb = s_axi_wstrb[1:0];
		end

		if (write_go)
		begin
			r_next.aw_got = 1'b0;
			r_next.w_got  = 1'b0;
			r_next.bvalid = 1'b1;
			r_next.bresp  = write_hit ? RESP_OKAY : RESP_SLVERR;
			// RULE4 reserved bits masked
			unique case (word_addr(r_reg.awaddr))
				ADDR_FIVE:
					r_next.level_sel_five = merge(r_reg.level_sel_five,
						r_reg.wdata, r_reg.wstrb, WMASK_FIVE);
				ADDR_SIX:
					r_next.level_sel_six = merge(r_reg.level_sel_six,
						r_reg.wdata, r_reg.wstrb, WMASK_SIX);
				ADDR_SEVEN:
					r_next.level_sel_seven = merge(r_reg.level_sel_seven,
						r_reg.wdata, r_reg.wstrb, WMASK_SEVEN);
				default:
				begin
				end
			endcase
		end
		if (r_reg.bvalid && s_axi_bready)
			r_next.bvalid = 1'b0;

		if (r_reg.rvalid && s_axi_rready)
			r_next.rvalid = 1'b0;
		if (s_axi_arvalid && s_axi_arready)
		begin
			r_next.rvalid = 1'b1;
			r_next.rresp  = RESP_OKAY;
			// RULE4 reserved bits read zero
			unique case (word_addr(s_axi_araddr))
				ADDR_FIVE:
					r_next.rdata = AXI_DW'(r_reg.level_sel_five & WMASK_FIVE);
				ADDR_SIX:
					r_next.rdata = AXI_DW'(r_reg.level_sel_six & WMASK_SIX);
				ADDR_SEVEN:
					r_next.rdata =
						AXI_DW'(r_reg.level_sel_seven & WMASK_SEVEN);
				default:
				begin
					r_next.rdata = '0;
					r_next.rresp = RESP_SLVERR;
				end
			endcase
		end
	end

	always_ff @(posedge mclk)
	begin
		// RULE5 everything disabled at reset
		if (srst)
		begin
			r_reg                 <= '0;
			r_reg.level_sel_five  <= RST_LEVEL_SEL;
			r_reg.level_sel_six   <= RST_LEVEL_SEL;
			r_reg.level_sel_seven <= RST_LEVEL_SEL;
		end
		else
			r_reg <= r_next;
	end

	////////////////////////////////////////////////////////////////////
	assign s_axi_bvalid = r_reg.bvalid;
	assign s_axi_bresp  = r_reg.bresp;
	assign s_axi_rvalid = r_reg.rvalid;
	assign s_axi_rdata  = r_reg.rdata;
	assign s_axi_rresp  = r_reg.rresp;

	////////////////////////////////////////////////////////////////////
	// slice each source's field out of the three registers
	logic [3*REG_W-1:0] all_sel;
	assign all_sel = {r_reg.level_sel_seven, r_reg.level_sel_six,
		r_reg.level_sel_five};

	for (genvar g = 0; g < NUM_SRC; g++)
	begin : g_src
		// RULE6 field placement from table
		assign pif.field[g] = all_sel[SRC_POS[g] +: FIELD_W];
	end
	assign pif.raw_irq = src_irq_in;

	ils_level_dec u_dec
	(
		.mclk (mclk),
		.srst (srst),
		.pif  (pif)
	);

	// RULE15 decoded view to arbitration
	assign src_enable = pif.enable;
	assign src_level  = pif.level;
	assign src_req    = pif.req;
endmodule

/* tb/ils_top_assertions.sv */
// concurrent checks on the priority-level block ports
module ils_top_assertions
	import ils_pkg::*;
(
	// clock and reset
	input wire logic					mclk,
	input wire logic					srst,
	// bus handshake
	input wire logic					s_axi_awready,
	input wire logic					s_axi_wready,
	input wire logic					s_axi_bvalid,
	input wire logic					s_axi_arvalid,
	input wire logic					s_axi_arready,
	input wire logic					s_axi_rvalid,
	input wire logic [ils_pkg::AXI_DW-1:0]		s_axi_rdata,
	input wire logic [1:0]				s_axi_rresp,
	// sources
	input wire logic [ils_pkg::NUM_SRC-1:0]		src_irq_in,
	input wire logic [ils_pkg::NUM_SRC-1:0]		src_enable,
	input wire logic [ils_pkg::NUM_SRC-1:0][1:0]	src_level,
	input wire logic [ils_pkg::NUM_SRC-1:0]		src_req
);
	timeunit 1ns;
	timeprecision 1ps;
	logic	bad_lvl;
	logic	dis_nz;

	default clocking @(posedge mclk); endclocking
	default disable iff (srst);

	// per-source scan; code 11 must never surface as a level above two
	always_comb
	begin
		bad_lvl = 1'b0;
		dis_nz = 1'b0;
		for (int i = 0; i < NUM_SRC; i++)
		begin
			if (src_level[i] == 2'h3)
				bad_lvl = 1'b1;
			if (!src_enable[i] && src_level[i] != 2'h0)
				dis_nz = 1'b1;
		end
	end
	////////////////////////////////////////////////////////////
	chk_rst_clear: assert property (disable iff (1'b0)
		srst |=> src_enable == '0 && src_level == '0 && src_req == '0
		&& !s_axi_bvalid && !s_axi_rvalid)
		else $error("outputs not cleared by reset");
	chk_lvl_max: assert property (!bad_lvl)
		else $error("level above two");
	chk_dis_level: assert property (!dis_nz)
		else $error("disabled source shows a level");
	chk_req_gate: assert property (src_req ==
		($past(src_irq_in) & src_enable))
		else $error("request not the raw line gated by enable");
	chk_ar_answer: assert property (s_axi_arvalid && s_axi_arready
		|=> s_axi_rvalid && !s_axi_arready)
		else $error("read not answered next cycle");
	chk_b_block: assert property (s_axi_bvalid
		|-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	chk_r_upper: assert property (s_axi_rvalid
		|-> s_axi_rdata[31:16] == 16'h0000)
		else $error("upper read half not zero");
	chk_r_err_zero: assert property (s_axi_rvalid && s_axi_rresp != 2'h0
		|-> s_axi_rdata == '0)
		else $error("error read carries data");
endmodule

bind ils_top ils_top_assertions CHK (.*);

/* tb/ils_src_model.sv */
// peripheral sources: raw request lines toggling at random
module ils_src_model
(
	// clock
	input wire logic				mclk,
	// raw requests
	output logic [ils_pkg::NUM_SRC-1:0]	irq
);
	timeunit 1ns;
	timeprecision 1ps;
	initial irq = '0;
	// bits move independently so gating is seen per source
	always @(posedge mclk)
		irq <= 22'($urandom);
endmodule

/* tb/ils_top_test.sv */
// self-checking bench of the priority-level register block
module ils_top_test;
	timeunit 1ns;
	timeprecision 1ps;
	import ils_pkg::*;
	logic			mclk = 0, srst = 1;
	logic			awv = 0, wv = 0, br = 0, arv = 0, rr = 0;
	logic			awr, wr, bv, arr, rv;
	logic [7:0]		awa = 0, ara = 0;
	logic [31:0]		wd = 0, rd;
	logic [3:0]		ws = 0;
	logic [1:0]		bs, rs;
	logic [NUM_SRC-1:0]	irq, en, rq;
	logic [NUM_SRC-1:0][1:0] lv;
	logic [15:0]		sh [3] = '{16'h0000, 16'h0000, 16'h0000};
	int			error_cnt = 0, n_tests = 0;
	localparam int POS [22] = '{14, 12, 10, 8, 4, 2, 0, 30, 28, 26, 24,
		22, 18, 16, 46, 44, 42, 40, 38, 36, 34, 32};

	always #2 mclk = ~mclk;
	ils_top DUT (.mclk(mclk), .srst(srst), .s_axi_awvalid(awv),
		.s_axi_awready(awr), .s_axi_awaddr(awa), .s_axi_wvalid(wv),
		.s_axi_wready(wr), .s_axi_wdata(wd), .s_axi_wstrb(ws),
		.s_axi_bvalid(bv), .s_axi_bready(br), .s_axi_bresp(bs),
		.s_axi_arvalid(arv), .s_axi_arready(arr), .s_axi_araddr(ara),
		.s_axi_rvalid(rv), .s_axi_rready(rr), .s_axi_rdata(rd),
		.s_axi_rresp(rs), .src_irq_in(irq), .src_enable(en),
		.src_level(lv), .src_req(rq));
	ils_src_model SRC (.mclk(mclk), .irq(irq));
	////////////////////////////////////////////////////////////
	task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
		n_tests++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected %s exp %h got %h", nm, e, g);
		end
	endtask

	// ready is looked at mid-cycle, where it is settled for the edge
	task automatic wr_reg(logic [7:0] a, logic [15:0] d, logic [3:0] s,
		output logic [1:0] r);
		logic ta, tw, tb;
		@(posedge mclk);
		awv <= 1;
		wv <= 1;
		br <= 1;
		awa <= a;
		wd <= {16'($urandom), d};
		ws <= s;
		tb = 0;
		while (!tb)
		begin
			@(negedge mclk);
			ta = awv & awr;
			tw = wv & wr;
			tb = bv;
			r = bs;
			@(posedge mclk);
			if (ta)
				awv <= 0;
			if (tw)
				wv <= 0;
		end
		br <= 0;
	endtask

	task automatic rd_reg(logic [7:0] a, output logic [31:0] d,
		output logic [1:0] r);
		logic ta, tr;
		@(posedge mclk);
		arv <= 1;
		rr <= 1;
		ara <= a;
		tr = 0;
		while (!tr)
		begin
			@(negedge mclk);
			ta = arv & arr;
			tr = rv;
			d = rd;
			r = rs;
			@(posedge mclk);
			if (ta)
				arv <= 0;
		end
		rr <= 0;
	endtask

	// reserved pairs: bits 7-6 of five, 5-4 of six
	function automatic logic [15:0] nxt(int k, logic [15:0] o,
		logic [15:0] d, logic [3:0] s);
		logic [15:0] m;
		m = {{8{s[1]}}, {8{s[0]}}};
		m = m & (k == 0 ? 16'hFF3F : k == 1 ? 16'hFFCF : 16'hFFFF);
		return (o & ~m) | (d & m);
	endfunction

	function automatic logic [1:0] exp_lvl(logic [1:0] f);
		return f == 2'h0 ? 2'h0 : f - 2'h1;
	endfunction

	task automatic wk(int k, logic [15:0] d, logic [3:0] s);
		logic [1:0] r;
		wr_reg(8'h14 + 8'(4 * k), d, s, r);
		chk("bresp", 0, r);
		sh[k] = nxt(k, sh[k], d, s);
	endtask

	task automatic chk_all;
		logic [47:0] cat;
		logic [NUM_SRC-1:0] p, e;
		logic [1:0] f, r;
		logic [31:0] d;
		for (int k = 0; k < 3; k++)
		begin
			rd_reg(8'h14 + 8'(4 * k), d, r);
			chk("rdata", {16'h0, sh[k]}, d);
			chk("rresp", 0, r);
		end
		cat = {sh[2], sh[1], sh[0]};
		@(negedge mclk);
		p = irq;
		@(negedge mclk);
		for (int i = 0; i < NUM_SRC; i++)
		begin
			f = cat[POS[i] +: 2];
			e[i] = f != 2'h0;
			chk("enable", e[i], en[i]);
			chk("level", exp_lvl(f), lv[i]);
		end
		chk("req", p & e, rq);
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", n_tests, error_cnt);
		if (error_cnt == 0 && n_tests > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	////////////////////////////////////////////////////////////
	initial
	begin
		logic [31:0] d;
		logic [1:0] r;
		void'($urandom(32'h5202));
		repeat (8) @(posedge mclk);
		srst <= 0;
		chk_all;
		$display("reset values test ended");
		for (int c = 0; c < 4; c++)
		begin
			for (int k = 0; k < 3; k++)
				wk(k, {8{2'(c)}}, 4'hF);
			chk_all;
		end
		$display("every code test ended");
		repeat (20)
		begin
			wk($urandom % 3, 16'($urandom), 4'($urandom));
			chk_all;
		end
		$display("random write test ended");
		wr_reg(8'h20, 16'hFFFF, 4'hF, r);
		chk("bresp", 2, r);
		rd_reg(8'h10, d, r);
		chk("rresp", 2, r);
		chk("rdata", 0, d);
		// sub-word address bits are ignored; reserved pair still masked
		wr_reg(8'h17, 16'h5A5A, 4'h3, r);
		chk("bresp", 0, r);
		sh[0] = nxt(0, sh[0], 16'h5A5A, 4'h3);
		chk_all;
		$display("unmapped test ended");
		@(posedge mclk);
		srst <= 1;
		repeat (2) @(posedge mclk);
		srst <= 0;
		sh = '{16'h0000, 16'h0000, 16'h0000};
		chk_all;
		$display("mid-run reset test ended");
		final_report;
	end

	// whole run needs under five hundred cycles
	initial
	begin
		repeat (20000) @(posedge mclk);
		$display("watchdog expired");
		error_cnt++;
		final_report;
	end
endmodule
